// *** ppcfg_host_model.sv ***
// Behavioural configuration host: drives the link clock, the data pins and the request.
// Assumes the loader samples data on the rising edge of the configuration clock.
`timescale 1ns/1ps
module ppcfg_host_model (
    output logic config_clock_o,
    output logic config_request_n_o,
    output logic [ppcfg_pkg::PIN_W-1:0] data_o
);
    import ppcfg_pkg::*;
    // ----------------------------------------------------------------
    // Host drive.
    // ----------------------------------------------------------------
    // The clock idles low between frames so that no stray edge reaches the port.
    initial begin
        config_clock_o = 1'b0;
        config_request_n_o = 1'b1;
        data_o = '0;
    end
    // one word per period
    // New data lands just after the fall, half a period ahead of the capturing rise.
    task automatic send_word(input logic [PIN_W-1:0] w);
        data_o <= w;
        #40 config_clock_o = 1'b1;
        #40 config_clock_o = 1'b0;
    endtask
    // trailing clock edges
    // The data pins are held, so the clock stays driven with defined data.
    task automatic edges(input int n);
        for (int i = 0; i < n; i++) begin
            send_word(data_o);
        end
    endtask
    // bus released
    // Released pins show the inverse of the last word, so a stale copy cannot match.
    task automatic release_bus();
        data_o <= ~data_o;
    endtask
    task automatic set_request(input logic v);
        config_request_n_o <= v;
    endtask
endmodule

// *** ppcfg_loader.sv ***
// Passive parallel configuration port, one data word per configuration clock.
// Assumes an external host drives config_clock, the data pins and the request line,
// and that a downstream configuration store consumes cfg_data_o and reports errors.
`timescale 1ns/1ps
module ppcfg_loader #(
    parameter int unsigned IMAGE_BYTES = 8192
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic config_clock_i,
    input wire logic config_request_n_i,
    input wire logic mode_x16_i,
    input wire logic [ppcfg_pkg::PIN_W-1:0] data_pin_i,
    output logic [ppcfg_pkg::PIN_W-1:0] data_pin_o,
    output logic [ppcfg_pkg::PIN_W-1:0] data_pin_oe_n_o,
    output logic status_n_o,
    output logic config_complete_o,
    output logic init_done_o,
    output logic init_done_oe_n_o,
    output logic [ppcfg_pkg::WORD_W-1:0] cfg_data_o,
    output logic cfg_valid_o,
    input wire logic cfg_error_i,
    input wire logic [ppcfg_pkg::PIN_W-1:0] user_out_i,
    input wire logic [ppcfg_pkg::PIN_W-1:0] user_oe_n_i,
    output logic [ppcfg_pkg::PIN_W-1:0] user_in_o
);
    import ppcfg_pkg::*;

    // ----------------------------------------------------------------
    // Link domain: runs on config_clock only while the controller is in the load, finish or user state.
    // ----------------------------------------------------------------
    logic link_hold;
    logic link_rst_n;
    logic user_flag;
    logic x16;
    logic link_stop;
    logic link_x16;
    logic [WORD_W-1:0] link_word;
    logic [WORD_W-1:0] next_link_word;
    logic link_tog;
    logic next_link_tog;
    logic [CNT_W-1:0] link_words;
    logic [CNT_W-1:0] next_link_words;
    logic link_full;
    logic [1:0] fall_cnt;
    logic [1:0] next_fall_cnt;
    logic link_init;

    // The hold flop is released on the same system clock edge that raises the status line,
    // so the stopped link clock never has to clock a reset release.
    assign link_rst_n = ~link_hold;
    // Words are counted, not bytes: the width flag reaches this domain only after two
    // link edges, and the limit it selects is not needed before the third word.
    // Limitation: an image of fewer than three words is not supported.
    assign link_full = link_words >= (link_x16 ? CNT_W'(IMAGE_BYTES / 2) :
                                      CNT_W'(IMAGE_BYTES));
    assign link_init = fall_cnt == 2'(DONE_EDGES);

    ppcfg_sync2 #(.WIDTH(2)) u_link_sync (
        .clk_i(config_clock_i),
        .nrst_i(link_rst_n),
        .en_i(1'b1),
        .d_i({user_flag, x16}),
        .q_o({link_stop, link_x16})
    );

    always_comb begin
        next_link_word = link_word;
        next_link_tog = link_tog;
        next_link_words = link_words;
        if (!link_stop) begin
            next_link_word = data_pin_i[WORD_W-1:0];
            next_link_tog = ~link_tog;
            if (!link_full) begin
                next_link_words = link_words + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge config_clock_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            link_word <= 16'h0000;
            link_tog <= 1'b0;
            link_words <= 32'h00000000;
        end else begin
            link_word <= next_link_word;
            link_tog <= next_link_tog;
            link_words <= next_link_words;
        end
    end

    // Falling edges after the last byte start initialisation; the host may keep
    // clocking, so extra edges are harmless once the count is reached.
    always_comb begin
        next_fall_cnt = fall_cnt;
        if (link_full && !link_init) begin
            next_fall_cnt = fall_cnt + 2'h1;
        end
    end

    always_ff @(negedge config_clock_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            fall_cnt <= 2'h0;
        end else begin
            fall_cnt <= next_fall_cnt;
        end
    end

    // ----------------------------------------------------------------
    // System domain: synchronisers.
    // ----------------------------------------------------------------
    logic req_s;
    logic mode_s;
    logic tog_s;
    logic init_s;
    logic [PIN_W-1:0] pins_s;

    ppcfg_sync2 #(.WIDTH(4)) u_ctl_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .en_i(ce_i),
        .d_i({config_request_n_i, mode_x16_i, link_tog, link_init}),
        .q_o({req_s, mode_s, tog_s, init_s})
    );

    ppcfg_sync2 #(.WIDTH(PIN_W)) u_pin_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .en_i(ce_i),
        .d_i(data_pin_i),
        .q_o(pins_s)
    );

    // ----------------------------------------------------------------
    // System domain: sequence control.
    // ----------------------------------------------------------------
    cfg_state_t state;
    cfg_state_t next_state;
    logic [12:0] por_cnt;
    logic [12:0] next_por_cnt;
    logic [CNT_W-1:0] bytes;
    logic [CNT_W-1:0] next_bytes;
    logic tog_d;
    logic tog_edge;
    logic next_x16;
    logic init_en;
    logic next_init_en;
    logic next_link_hold;
    logic next_user_flag;
    logic [WORD_W-1:0] next_cfg_data;
    logic next_cfg_valid;

    // The link word is held a full link period (80 ns) and the toggle is seen
    // within three system clocks (75 ns), so the word is read while still stable.
    assign tog_edge = tog_s ^ tog_d;

    function automatic logic run_state(input cfg_state_t s);
        run_state = (s == ST_LOAD) || (s == ST_FINISH) || (s == ST_USER);
    endfunction

    always_comb begin
        next_state = state;
        next_por_cnt = por_cnt;
        next_bytes = bytes;
        next_x16 = x16;
        next_init_en = init_en;
        next_cfg_data = cfg_data_o;
        next_cfg_valid = 1'b0;
        case (state)
            ST_POR: begin
                next_por_cnt = por_cnt + 13'h0001;
                if (por_cnt == 13'(POR_CYCLES - 1)) begin
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                next_bytes = '0;
                next_init_en = 1'b0;
                next_x16 = mode_s;
                if (req_s) begin
                    next_state = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (tog_edge) begin
                    next_cfg_valid = 1'b1;
                    next_cfg_data = x16 ? link_word : {8'h00, link_word[BYTE_W-1:0]};
                    next_bytes = bytes + (x16 ? CNT_W'(2) : CNT_W'(1));
                    if (bytes == '0) begin
                        next_init_en = link_word[INIT_EN_BIT];
                    end
                end
                if (cfg_error_i) begin
                    next_state = ST_FAIL;
                end else if (bytes >= CNT_W'(IMAGE_BYTES)) begin
                    next_state = ST_FINISH;
                end
            end
            ST_FINISH: begin
                if (init_s) begin
                    next_state = ST_USER;
                end
            end
            ST_USER: next_state = ST_USER;
            ST_FAIL: next_state = ST_FAIL;
            default: next_state = ST_HOLD;
        endcase
        if (state != ST_POR && !req_s) begin
            next_state = ST_HOLD;
        end
        if (!ce_i) begin
            next_state = state;
            next_por_cnt = por_cnt;
            next_bytes = bytes;
            next_x16 = x16;
            next_init_en = init_en;
            next_cfg_data = cfg_data_o;
            next_cfg_valid = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= ST_POR;
            por_cnt <= 13'h0000;
            bytes <= 32'h00000000;
            x16 <= 1'b0;
            init_en <= 1'b0;
            tog_d <= 1'b0;
            cfg_data_o <= 16'h0000;
            cfg_valid_o <= 1'b0;
        end else begin
            state <= next_state;
            por_cnt <= next_por_cnt;
            bytes <= next_bytes;
            x16 <= next_x16;
            init_en <= next_init_en;
            tog_d <= ce_i ? tog_s : tog_d;
            cfg_data_o <= next_cfg_data;
            cfg_valid_o <= next_cfg_valid;
        end
    end

    // ----------------------------------------------------------------
    // System domain: pin drivers, registered from the next state.
    // ----------------------------------------------------------------
    logic next_status_n;
    logic next_complete;
    logic next_init_done;
    logic next_init_oe_n;
    logic [PIN_W-1:0] next_pin_o;
    logic [PIN_W-1:0] next_pin_oe_n;
    logic [PIN_W-1:0] next_user_in;

    always_comb begin
        next_status_n = run_state(next_state);
        next_complete = (next_state == ST_FINISH) || (next_state == ST_USER);
        next_user_flag = next_state == ST_USER;
        next_link_hold = !run_state(next_state);
        next_init_oe_n = !(next_init_en && run_state(next_state));
        next_init_done = next_state == ST_USER;
        next_pin_o = next_user_flag ? user_out_i : '0;
        next_pin_oe_n = next_user_flag ? user_oe_n_i : PINS_RELEASED;
        next_user_in = next_user_flag ? pins_s : '0;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            status_n_o <= 1'b0;
            config_complete_o <= 1'b0;
            init_done_o <= 1'b0;
            init_done_oe_n_o <= 1'b1;
            link_hold <= 1'b1;
            user_flag <= 1'b0;
            data_pin_o <= 32'h00000000;
            data_pin_oe_n_o <= 32'hFFFFFFFF;
            user_in_o <= 32'h00000000;
        end else begin
            status_n_o <= next_status_n;
            config_complete_o <= next_complete;
            init_done_o <= next_init_done;
            init_done_oe_n_o <= next_init_oe_n;
            link_hold <= next_link_hold;
            user_flag <= next_user_flag;
            data_pin_o <= next_pin_o;
            data_pin_oe_n_o <= next_pin_oe_n;
            user_in_o <= next_user_in;
        end
    end

    // ----------------------------------------------------------------
    // Assertions and covers on the system clock.
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    property p_req_abort;
        ce_i && state != ST_POR && !req_s |=> state == ST_HOLD && !status_n_o;
    endproperty
    a_req_abort: assert property (p_req_abort) else $error("request low did not restart");

    property p_user_high;
        state == ST_USER |-> status_n_o && config_complete_o;
    endproperty
    a_user_high: assert property (p_user_high) else $error("user mode lines not high");

    property p_por_low;
        state == ST_POR |-> !status_n_o && por_cnt < 13'(POR_CYCLES);
    endproperty
    a_por_low: assert property (p_por_low) else $error("status high during power-on");

    property p_done_low;
        state inside {ST_POR, ST_HOLD, ST_LOAD, ST_FAIL} |-> !config_complete_o;
    endproperty
    a_done_low: assert property (p_done_low) else $error("complete high before load end");

    property p_ignore_clock;
        state == ST_USER && req_s && ce_i |=> state == ST_USER && !cfg_valid_o;
    endproperty
    a_ignore_clock: assert property (p_ignore_clock) else $error("activity after completion");

    property p_lanes;
        cfg_valid_o && !x16 |-> cfg_data_o[WORD_W-1:BYTE_W] == 8'h00;
    endproperty
    a_lanes: assert property (p_lanes) else $error("upper byte used in 8-bit mode");

    property p_pins_user;
        data_pin_oe_n_o != PINS_RELEASED |-> state == ST_USER;
    endproperty
    a_pins_user: assert property (p_pins_user) else $error("pins driven before user mode");

    property p_done_full;
        $rose(config_complete_o) |-> bytes >= CNT_W'(IMAGE_BYTES) && state == ST_FINISH;
    endproperty
    a_done_full: assert property (p_done_full) else $error("complete before full image");

    property p_init_low;
        init_en && run_state(state) && state != ST_USER |-> !init_done_oe_n_o && !init_done_o;
    endproperty
    a_init_low: assert property (p_init_low) else $error("init-done not held low");

    property p_word_valid;
        ce_i && tog_edge && state == ST_LOAD && req_s && !cfg_error_i |=> cfg_valid_o;
    endproperty
    a_word_valid: assert property (p_word_valid) else $error("captured word not delivered");

    property p_user_init;
        state == ST_USER |-> init_done_o;
    endproperty
    a_user_init: assert property (p_user_init) else $error("init-done low in user mode");

    c_load: cover property (state == ST_LOAD ##1 state == ST_FINISH);
    c_user: cover property (state == ST_FINISH ##1 state == ST_USER);
    c_fail: cover property (state == ST_LOAD ##1 state == ST_FAIL);
    c_restart: cover property (state == ST_USER ##1 state == ST_HOLD);
endmodule

// *** ppcfg_pkg.sv ***
// Constants, state type and timing counts for the parallel configuration loader.
// Assumes a 40 MHz system clock and a host that drives the configuration clock.
package ppcfg_pkg;
    // ----------------------------------------------------------------
    // Timing.
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int POR_DELAY_US = 100;
    localparam int POR_CYCLES = (POR_DELAY_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
                                POR_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int DONE_EDGES = 2;
    // ----------------------------------------------------------------
    // Widths and field positions.
    // ----------------------------------------------------------------
    localparam int PIN_W = 32;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int CNT_W = 32;
    localparam int INIT_EN_BIT = 0;
    localparam logic [PIN_W-1:0] PINS_RELEASED = 32'hFFFFFFFF;
    // ----------------------------------------------------------------
    // Controller states.
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_POR,
        ST_HOLD,
        ST_LOAD,
        ST_FINISH,
        ST_USER,
        ST_FAIL
    } cfg_state_t;
endpackage

// *** ppcfg_sync2.sv ***
// Two-flop level synchroniser with an enable, used for the control, toggle and pin crossings; the link word crosses without one.
// Assumes the input is a level or a toggle that stays put for several destination clocks.
`timescale 1ns/1ps
module ppcfg_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic en_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_q;

    // The first stage feeds only the second stage.
    always_comb begin
        next_meta = en_i ? d_i : meta;
        next_q = en_i ? meta : q_o;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= next_meta;
            q_o <= next_q;
        end
    end
endmodule

// *** test_passive_parallel_config_load.sv ***
// Self-checking bench for the parallel configuration loader with a host model.
// Assumes ppcfg_pkg and ppcfg_loader are compiled first; images are 8 bytes long.
`timescale 1ns/1ps
module test_passive_parallel_config_load;
    import ppcfg_pkg::*;
    localparam int unsigned IMG = 8;
    localparam int LVL_DONE = 0;
    localparam int LVL_INIT = 1;
    localparam int LVL_STATUS = 2;
    logic clk_i, nrst_i, ce_i, mode_x16_i, cfg_error_i;
    logic config_clock, config_request_n, init_done_pin;
    logic status_n_o, config_complete_o, init_done_o, init_done_oe_n_o, cfg_valid_o;
    logic [PIN_W-1:0] host_data, data_pin_i, data_pin_o, data_pin_oe_n_o;
    logic [PIN_W-1:0] user_out_i, user_oe_n_i, user_in_o;
    logic [WORD_W-1:0] cfg_data_o;
    logic [WORD_W-1:0] words[$];
    logic [WORD_W-1:0] exp_q[$];
    int fails, num_checks;
    // ----------------------------------------------------------------
    // Wiring, clock and monitor.
    // ----------------------------------------------------------------
    // Each pin carries the loader's value where it drives, else the host's.
    assign data_pin_i = (data_pin_o & ~data_pin_oe_n_o) | (host_data & data_pin_oe_n_o);
    assign init_done_pin = init_done_oe_n_o ? 1'b1 : init_done_o; // Pull-up when floating.
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (cfg_valid_o === 1'b1) words.push_back(cfg_data_o);
    end
    ppcfg_host_model host (.config_clock_o(config_clock),
        .config_request_n_o(config_request_n), .data_o(host_data));
    ppcfg_loader #(.IMAGE_BYTES(IMG)) dut (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
        .config_clock_i(config_clock), .config_request_n_i(config_request_n),
        .mode_x16_i(mode_x16_i), .data_pin_i(data_pin_i), .data_pin_o(data_pin_o),
        .data_pin_oe_n_o(data_pin_oe_n_o), .status_n_o(status_n_o),
        .config_complete_o(config_complete_o), .init_done_o(init_done_o),
        .init_done_oe_n_o(init_done_oe_n_o), .cfg_data_o(cfg_data_o),
        .cfg_valid_o(cfg_valid_o), .cfg_error_i(cfg_error_i), .user_out_i(user_out_i),
        .user_oe_n_i(user_oe_n_i), .user_in_o(user_in_o));
    // ----------------------------------------------------------------
    // Shared tasks.
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    // Picks the watched output by number, so the wait needs no reference argument.
    function automatic logic level_of(input int k);
        case (k)
            LVL_DONE: level_of = config_complete_o;
            LVL_INIT: level_of = init_done_o;
            default: level_of = status_n_o;
        endcase
    endfunction
    // Bounded wait; a level that never arrives shows up as a mismatch.
    task automatic wait_level(input int k, input logic lvl, input int lim);
        int n;
        n = 0;
        while (level_of(k) !== lvl && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        check({31'h0, level_of(k)}, {31'h0, lvl});
    endtask
    // Sends a whole image; the first word carries the init-done enable bit.
    task automatic load_image(input logic x16, input logic [15:0] junk);
        logic [15:0] w;
        int nw;
        nw = x16 ? IMG / 2 : IMG;
        words.delete();
        exp_q.delete();
        #107;
        for (int i = 0; i < nw; i++) begin
            w = x16 ? 16'h1235 + 16'(i * 'h1111) : {junk[15:8], 8'(8'h31 + i)};
            host.send_word({junk, w});
            exp_q.push_back(x16 ? w : {8'h00, w[7:0]});
        end
        check({31'h0, config_complete_o}, 32'h0);
        check({31'h0, init_done_pin}, 32'h0);
        wait_level(LVL_DONE, 1'b1, 20);
        check(words.size(), nw);
        for (int i = 0; i < nw && i < words.size(); i++) begin
            check(words[i], exp_q[i]);
        end
    endtask
    // Finishes with two falls, then checks user mode and the ignored clock.
    task automatic enter_user();
        host.edges(2);
        wait_level(LVL_INIT, 1'b1, 20);
        check({init_done_pin, status_n_o, config_complete_o, config_request_n}, 4'hF);
        host.release_bus();
        repeat (8) @(posedge clk_i);
        check(data_pin_oe_n_o, user_oe_n_i);
        check(data_pin_o, user_out_i);
        check(user_in_o[15:0], 16'hA5C3);
        check(user_in_o[31:16], host_data[31:16]);
        words.delete();
        host.edges(3);
        repeat (8) @(posedge clk_i);
        check(words.size(), 0);
        check({31'h0, config_complete_o}, 32'h1);
    endtask
    // Drops the request, checks that user mode is left, then restarts the load.
    task automatic restart(input logic x16);
        host.set_request(1'b0);
        repeat (10) @(posedge clk_i);
        check({status_n_o, config_complete_o, init_done_o}, 3'h0);
        mode_x16_i <= x16;
        repeat (4) @(posedge clk_i);
        host.set_request(1'b1);
        wait_level(LVL_STATUS, 1'b1, 20);
    endtask
    // ----------------------------------------------------------------
    // Scenarios.
    // ----------------------------------------------------------------
    task automatic test_power_on();
        repeat (10) @(posedge clk_i);
        check({status_n_o, config_complete_o}, 2'h0);
        repeat (3980) @(posedge clk_i);
        check({status_n_o, config_complete_o}, 2'h0);
        wait_level(LVL_STATUS, 1'b1, 40);
        $display("test power_on done");
    endtask
    task automatic test_load_x16();
        load_image(1'b1, 16'hDEAD);
        enter_user();
        $display("test load_x16 done");
    endtask
    task automatic test_request_x8();
        restart(1'b0);
        load_image(1'b0, 16'hBEEF);
        enter_user();
        $display("test request_x8 done");
    endtask
    // A low clock enable holds user mode even while the request is dropped;
    // the request stays low so that the next restart begins from hold.
    task automatic test_freeze();
        ce_i <= 1'b0;
        host.set_request(1'b0);
        repeat (10) @(posedge clk_i);
        check({status_n_o, config_complete_o, init_done_o}, 3'h7);
        ce_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        check({status_n_o, config_complete_o, init_done_o}, 3'h0);
        $display("test freeze done");
    endtask
    // An error in mid-load must keep the done line low and drop the status line.
    task automatic test_error();
        restart(1'b1);
        #107;
        host.send_word(32'h00001235);
        @(posedge clk_i);
        cfg_error_i <= 1'b1;
        for (int i = 0; i < 3; i++) host.send_word(32'h00002000 + i);
        repeat (10) @(posedge clk_i);
        check({31'h0, config_complete_o}, 32'h0);
        check({31'h0, status_n_o}, 32'h0);
        cfg_error_i <= 1'b0;
        $display("test error done");
    endtask
    // ----------------------------------------------------------------
    // Run control.
    // ----------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // The tests take about 105 us; 1 ms leaves ample margin.
    initial begin
        #1000000;
        fails++;
        complete_run();
    end
    initial begin
        nrst_i = 1'b0;
        ce_i = 1'b1;
        mode_x16_i = 1'b1;
        cfg_error_i = 1'b0;
        user_out_i = 32'h0000A5C3;
        user_oe_n_i = 32'hFFFF0000;
        fails = 0;
        num_checks = 0;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        test_power_on();
        test_load_x16();
        test_request_x8();
        test_freeze();
        test_error();
        complete_run();
    end
endmodule
